// >>> design/pfs_fir_stage.sv
// Decimating sum-of-products FIR stage with APB register access
// Function
// R1 - Keep 160 newest I/Q samples, 20 bits
// R2 - Coefficient memory holds 256 20-bit words
// R3 - One I and one Q tap per clock
// R4 - Outputs carry 24 data bits
// R5 - Decimation register holds factor minus one
// R6 - Phase value preloads the decimation counter
// R7 - Tap count minus one; software keeps limits
// R8 - Coefficients are 20-bit two's complement
// R9 - Low coefficient addresses meet older samples
// R10 - Software writes full coefficient sets
// R11 - Two written pages, one contiguous filter space
// R12 - 160-entry I/Q store used circularly
// R13 - Software clears sample memory at start
// R14 - Oldest sample times offset coefficient, accumulate onward
// R15 - Offset selects filter start in coefficient memory
// R16 - One output per decimation-factor inputs
// R17 - Control bit 9 selects alternate input source
// R18 - Page bit selects low or high write page
// R19 - Counter restarts from zero after each trigger
`timescale 1ns/1ps
module pfs_fir_stage (
   input  wire logic                         sys_clk_in,
   input  wire logic                         resetn_in,
   // APB slave
   input  wire logic                         psel_in,
   input  wire logic                         penable_in,
   input  wire logic                         pwrite_in,
   input  wire logic [pfs_pkg::PADDR_W-1:0]  paddr_in,
   input  wire logic [31:0]                  pwdata_in,
   output logic      [31:0]                  prdata_out,
   output logic                              pready_out,
   output logic                              pslverr_out,
   // Own comb decimator
   input  wire logic [pfs_pkg::SMP_W-1:0]    own_i_in,
   input  wire logic [pfs_pkg::SMP_W-1:0]    own_q_in,
   input  wire logic                         own_valid_in,
   // Partner channel comb decimator
   input  wire logic [pfs_pkg::SMP_W-1:0]    alt_i_in,
   input  wire logic [pfs_pkg::SMP_W-1:0]    alt_q_in,
   input  wire logic                         alt_valid_in,
   // Filter output
   output logic      [pfs_pkg::OUT_W-1:0]    out_i_out,
   output logic      [pfs_pkg::OUT_W-1:0]    out_q_out,
   output logic                              out_valid_out
);
   pfs_pkg::pfs_state_t r;
   pfs_pkg::pfs_state_t n;

   logic [pfs_pkg::SMP_W-1:0]  smp_i;
   logic [pfs_pkg::SMP_W-1:0]  smp_q;
   logic                       smp_v;
   logic [pfs_pkg::SMP_W-1:0]  rd_i;
   logic [pfs_pkg::SMP_W-1:0]  rd_q;
   logic [pfs_pkg::COEF_W-1:0] rd_c;
   logic [pfs_pkg::COEF_W-1:0] bus_c;
   logic [7:0]                 idx;
   logic                       is_coef;
   logic                       mapped;
   logic                       acc_cyc;
   logic                       wr_cyc;
   logic                       coef_we;
   logic [7:0]                 coef_waddr;
   logic [7:0]                 daddr;
   logic [8:0]                 dsum;
   logic [7:0]                 caddr;
   logic [8:0]                 first_pos;
   logic                       trig;
   logic [pfs_pkg::PROD_W-1:0] prod_i;
   logic [pfs_pkg::PROD_W-1:0] prod_q;

   // Saturate the accumulator to the output width
   function automatic logic [pfs_pkg::OUT_W-1:0] sat_out(input logic [pfs_pkg::ACC_W-1:0] a);
      logic [pfs_pkg::ACC_W-pfs_pkg::OUT_LSB-pfs_pkg::OUT_W:0] top;
      top = a[pfs_pkg::ACC_W-1:pfs_pkg::OUT_LSB+pfs_pkg::OUT_W-1];
      sat_out = a[pfs_pkg::OUT_LSB+pfs_pkg::OUT_W-1:pfs_pkg::OUT_LSB];
      if (!((&top) || !(|top))) begin
         sat_out = {a[pfs_pkg::ACC_W-1], {(pfs_pkg::OUT_W-1){~a[pfs_pkg::ACC_W-1]}}};
      end
   endfunction

   // Input source selection
   always_comb begin
      if (r.ctrl[pfs_pkg::CTRL_SRC_BIT]) begin // R17
         smp_i = alt_i_in;
         smp_q = alt_q_in;
         smp_v = alt_valid_in;
      end else begin
         smp_i = own_i_in;
         smp_q = own_q_in;
         smp_v = own_valid_in;
      end
   end

   // Bus decode; one wait state on every access
   assign idx        = paddr_in[pfs_pkg::PADDR_W-1:2];
   assign is_coef    = (idx <= pfs_pkg::IDX_COEF_LAST);
   assign mapped     = is_coef || (idx >= pfs_pkg::IDX_DEC_M1 && idx <= pfs_pkg::IDX_CTRL)
                       || idx == pfs_pkg::IDX_RUN || idx == pfs_pkg::IDX_STATUS;
   assign acc_cyc    = psel_in && penable_in && r.wait_st;
   assign wr_cyc     = acc_cyc && pwrite_in && mapped;
   assign coef_we    = wr_cyc && is_coef;
   assign coef_waddr = {r.ctrl[pfs_pkg::CTRL_PAGE_BIT], idx[6:0]}; // R11 R18

   assign pready_out  = acc_cyc;
   assign pslverr_out = acc_cyc && !mapped;
   // Coefficient words come straight from the memory's output register
   assign prdata_out  = (acc_cyc && is_coef && !pwrite_in)
                        ? {{(32-pfs_pkg::COEF_W){bus_c[pfs_pkg::COEF_W-1]}}, bus_c} // R8
                        : r.prdata;

   // Data address walks from the oldest used sample toward the newest
   assign dsum  = {1'b0, r.start} + {1'b0, r.k};
   assign daddr = (dsum >= pfs_pkg::SMP_DEPTH9) ? 8'(dsum - pfs_pkg::SMP_DEPTH9) : dsum[7:0]; // R12
   // Wraps from tap 127 into 128 with no page boundary
   assign caddr = r.coef_off + r.k; // R11 R15 R9

   // Position of the oldest sample for this output
   assign first_pos = ({1'b0, r.wptr} >= {1'b0, r.ntaps_m1})
                      ? {1'b0, r.wptr} - {1'b0, r.ntaps_m1}
                      : {1'b0, r.wptr} + pfs_pkg::SMP_DEPTH9 - {1'b0, r.ntaps_m1};

   assign trig = smp_v && r.run && (r.dcnt == r.dec_m1); // R16

   // Same coefficient feeds both products
   assign prod_i = $signed(rd_i) * $signed(rd_c); // R3
   assign prod_q = $signed(rd_q) * $signed(rd_c); // R3

   pfs_sample_mem u_smp (
      .sys_clk_in  (sys_clk_in),
      .we_in       (smp_v && r.run),
      .waddr_in    (r.wptr),
      .wdata_i_in  (smp_i),
      .wdata_q_in  (smp_q),
      .raddr_in    (daddr),
      .rdata_i_out (rd_i),
      .rdata_q_out (rd_q)
   );

   pfs_coef_mem u_coef ( // R2
      .sys_clk_in  (sys_clk_in),
      .we_in       (coef_we),
      .waddr_in    (coef_waddr),
      .wdata_in    (pwdata_in[pfs_pkg::COEF_W-1:0]),
      .raddr_a_in  (caddr),
      .raddr_b_in  (coef_waddr),
      .rdata_a_out (rd_c),
      .rdata_b_out (bus_c)
   );

   always_comb begin
      n = r;
      n.wait_st = psel_in && penable_in && !r.wait_st;
      n.out_v   = 1'b0;

      // Register read data captured in the first access cycle
      n.prdata = 32'h0000_0000;
      case (idx)
         pfs_pkg::IDX_DEC_M1:   n.prdata[7:0] = r.dec_m1;
         pfs_pkg::IDX_PHASE:    n.prdata[7:0] = r.phase;
         pfs_pkg::IDX_NTAPS_M1: n.prdata[7:0] = r.ntaps_m1;
         pfs_pkg::IDX_COEF_OFF: n.prdata[7:0] = r.coef_off;
         pfs_pkg::IDX_CTRL:     n.prdata[pfs_pkg::CTRL_W-1:0] = r.ctrl;
         pfs_pkg::IDX_RUN:      n.prdata[0] = r.run;
         pfs_pkg::IDX_STATUS: begin
            n.prdata[pfs_pkg::STAT_BUSY_BIT] = (r.fsm != pfs_pkg::PFS_IDLE);
            n.prdata[pfs_pkg::STAT_OVR_BIT]  = r.ovr;
            n.prdata[pfs_pkg::STAT_WPTR_LSB +: 8] = r.wptr;
         end
         default: n.prdata = 32'h0000_0000;
      endcase

      if (wr_cyc) begin
         case (idx)
            pfs_pkg::IDX_DEC_M1:   n.dec_m1   = pwdata_in[7:0]; // R5
            pfs_pkg::IDX_PHASE:    n.phase    = pwdata_in[7:0];
            pfs_pkg::IDX_NTAPS_M1: n.ntaps_m1 = pwdata_in[7:0]; // R7
            pfs_pkg::IDX_COEF_OFF: n.coef_off = pwdata_in[7:0]; // R15
            pfs_pkg::IDX_CTRL:     n.ctrl     = pwdata_in[pfs_pkg::CTRL_W-1:0];
            pfs_pkg::IDX_RUN:      n.run      = pwdata_in[0];
            pfs_pkg::IDX_STATUS: begin
               if (pwdata_in[pfs_pkg::STAT_OVR_BIT]) begin
                  n.ovr = 1'b0;
               end
            end
            default: n.run = r.run;
         endcase
      end

      // Sample store and decimation counter
      if (!r.run) begin
         n.dcnt = r.phase; // R6
      end else if (smp_v) begin
         n.wptr = (r.wptr == pfs_pkg::SMP_LAST) ? 8'h00 : r.wptr + 8'h01; // R1 R12
         if (trig) begin
            n.dcnt = 8'h00; // R19
         end else begin
            n.dcnt = r.dcnt + 8'h01;
         end
      end

      // Products arrive one cycle after their addresses
      n.macv = (r.fsm == pfs_pkg::PFS_RUN);
      if (r.macv) begin
         n.acc_i = r.acc_i + {{(pfs_pkg::ACC_W-pfs_pkg::PROD_W){prod_i[pfs_pkg::PROD_W-1]}}, prod_i}; // R14
         n.acc_q = r.acc_q + {{(pfs_pkg::ACC_W-pfs_pkg::PROD_W){prod_q[pfs_pkg::PROD_W-1]}}, prod_q}; // R14
      end

      case (r.fsm)
         pfs_pkg::PFS_IDLE: begin
            if (trig) begin
               n.start = first_pos[7:0]; // R14
               n.k     = 8'h00;
               n.acc_i = '0;
               n.acc_q = '0;
               n.fsm   = pfs_pkg::PFS_RUN;
            end
         end
         pfs_pkg::PFS_RUN: begin
            n.k = r.k + 8'h01;
            if (r.k == r.ntaps_m1) begin // R7
               n.fsm = pfs_pkg::PFS_DRAIN;
            end
         end
         pfs_pkg::PFS_DRAIN: begin
            n.fsm = pfs_pkg::PFS_DONE;
         end
         pfs_pkg::PFS_DONE: begin
            n.out_i = sat_out(r.acc_i); // R4
            n.out_q = sat_out(r.acc_q); // R4
            n.out_v = 1'b1; // R16
            n.fsm   = pfs_pkg::PFS_IDLE;
         end
         default: n.fsm = pfs_pkg::PFS_IDLE;
      endcase

      // A trigger while busy is dropped and flagged; set beats clear
      if (trig && r.fsm != pfs_pkg::PFS_IDLE) begin
         n.ovr = 1'b1;
      end
   end

   always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         r          <= '0;
         r.dec_m1   <= pfs_pkg::RST_BYTE;
         r.phase    <= pfs_pkg::RST_BYTE;
         r.ntaps_m1 <= pfs_pkg::RST_BYTE;
         r.coef_off <= pfs_pkg::RST_BYTE;
         r.ctrl     <= pfs_pkg::RST_CTRL;
         r.fsm      <= pfs_pkg::PFS_IDLE;
      end else begin
         r <= n;
      end
   end

   assign out_i_out     = r.out_i;
   assign out_q_out     = r.out_q;
   assign out_valid_out = r.out_v;
endmodule

// >>> design/pfs_pkg.sv
// Constants, register map and state types of the programmable FIR stage
package pfs_pkg;
   localparam int SMP_W    = 20;
   localparam int COEF_W   = 20;
   localparam int OUT_W    = 24;
   localparam int ACC_W    = 48;
   localparam int PROD_W   = 40;
   localparam int OUT_LSB  = 19;
   localparam int SMP_DEPTH  = 160;
   localparam int COEF_DEPTH = 256;
   localparam int PADDR_W  = 10;

   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_COEF_LAST = 8'h7F;
   localparam logic [7:0] IDX_DEC_M1    = 8'hA0;
   localparam logic [7:0] IDX_PHASE     = 8'hA1;
   localparam logic [7:0] IDX_NTAPS_M1  = 8'hA2;
   localparam logic [7:0] IDX_COEF_OFF  = 8'hA3;
   localparam logic [7:0] IDX_CTRL      = 8'hA4;
   localparam logic [7:0] IDX_RUN       = 8'hAC;
   localparam logic [7:0] IDX_STATUS    = 8'hAD;

   localparam int CTRL_W        = 11;
   localparam int CTRL_PAGE_BIT = 8;
   localparam int CTRL_SRC_BIT  = 9;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_OVR_BIT  = 1;
   localparam int STAT_WPTR_LSB = 8;

   localparam logic [7:0]        RST_BYTE  = 8'h00;
   localparam logic [CTRL_W-1:0] RST_CTRL  = 11'h000;
   localparam logic [8:0]        SMP_DEPTH9 = 9'h0A0;
   localparam logic [7:0]        SMP_LAST   = 8'h9F;

   typedef enum logic [1:0] {
      PFS_IDLE  = 2'b00,
      PFS_RUN   = 2'b01,
      PFS_DRAIN = 2'b11,
      PFS_DONE  = 2'b10
   } pfs_fsm_t;

   typedef struct packed {
      logic [7:0]        dec_m1;
      logic [7:0]        phase;
      logic [7:0]        ntaps_m1;
      logic [7:0]        coef_off;
      logic [CTRL_W-1:0] ctrl;
      logic              run;
      logic              ovr;
      logic              wait_st;
      logic [31:0]       prdata;
      logic [7:0]        wptr;
      logic [7:0]        dcnt;
      pfs_fsm_t          fsm;
      logic [7:0]        k;
      logic [7:0]        start;
      logic              macv;
      logic [ACC_W-1:0]  acc_i;
      logic [ACC_W-1:0]  acc_q;
      logic [OUT_W-1:0]  out_i;
      logic [OUT_W-1:0]  out_q;
      logic              out_v;
   } pfs_state_t;
endpackage

// >>> design/pfs_sample_mem.sv
// Circular I/Q sample store, one write port and one registered read port
`timescale 1ns/1ps
module pfs_sample_mem (
   input  wire logic                      sys_clk_in,
   input  wire logic                      we_in,
   input  wire logic [7:0]                waddr_in,
   input  wire logic [pfs_pkg::SMP_W-1:0] wdata_i_in,
   input  wire logic [pfs_pkg::SMP_W-1:0] wdata_q_in,
   input  wire logic [7:0]                raddr_in,
   output logic      [pfs_pkg::SMP_W-1:0] rdata_i_out,
   output logic      [pfs_pkg::SMP_W-1:0] rdata_q_out
);
   // I half in the upper bits, Q half in the lower bits
   logic [2*pfs_pkg::SMP_W-1:0] mem [pfs_pkg::SMP_DEPTH];

   // No reset on the array; software zeroes it before use
   always_ff @(posedge sys_clk_in) begin
      if (we_in) begin
         mem[waddr_in] <= {wdata_i_in, wdata_q_in};
      end
      rdata_i_out <= mem[raddr_in][2*pfs_pkg::SMP_W-1:pfs_pkg::SMP_W];
      rdata_q_out <= mem[raddr_in][pfs_pkg::SMP_W-1:0];
   end
endmodule

// >>> design/pfs_coef_mem.sv
// Coefficient store: one write port, filter and bus read ports
`timescale 1ns/1ps
module pfs_coef_mem (
   input  wire logic                       sys_clk_in,
   input  wire logic                       we_in,
   input  wire logic [7:0]                 waddr_in,
   input  wire logic [pfs_pkg::COEF_W-1:0] wdata_in,
   input  wire logic [7:0]                 raddr_a_in,
   input  wire logic [7:0]                 raddr_b_in,
   output logic      [pfs_pkg::COEF_W-1:0] rdata_a_out,
   output logic      [pfs_pkg::COEF_W-1:0] rdata_b_out
);
   logic [pfs_pkg::COEF_W-1:0] mem [pfs_pkg::COEF_DEPTH];

   always_ff @(posedge sys_clk_in) begin
      if (we_in) begin
         mem[waddr_in] <= wdata_in;
      end
      rdata_a_out <= mem[raddr_a_in];
      rdata_b_out <= mem[raddr_b_in];
   end
endmodule

// >>> sim/pfs_fir_stage_asserts.sv
// Port-level checks of the FIR stage
`timescale 1ns/1ps
module pfs_fir_stage_asserts (
   input wire logic                         sys_clk_in,
   input wire logic                         resetn_in,
   input wire logic                         psel_in,
   input wire logic                         penable_in,
   input wire logic                         pwrite_in,
   input wire logic [pfs_pkg::PADDR_W-1:0]  paddr_in,
   input wire logic [31:0]                  pwdata_in,
   input wire logic [31:0]                  prdata_out,
   input wire logic                         pready_out,
   input wire logic                         pslverr_out,
   input wire logic [pfs_pkg::SMP_W-1:0]    own_i_in,
   input wire logic [pfs_pkg::SMP_W-1:0]    own_q_in,
   input wire logic                         own_valid_in,
   input wire logic [pfs_pkg::SMP_W-1:0]    alt_i_in,
   input wire logic [pfs_pkg::SMP_W-1:0]    alt_q_in,
   input wire logic                         alt_valid_in,
   input wire logic [pfs_pkg::OUT_W-1:0]    out_i_out,
   input wire logic [pfs_pkg::OUT_W-1:0]    out_q_out,
   input wire logic                         out_valid_out
);
   logic [7:0] idx;
   logic       hit;
   logic       map;
   logic       src_r;
   logic [7:0] nt_r;
   logic [8:0] since_r;
   assign idx = paddr_in[9:2];
   assign hit = pready_out && pwrite_in && !pslverr_out;
   assign map = idx <= 8'h7F || (idx >= 8'hA0 && idx <= 8'hA4) || idx == 8'hAC || idx == 8'hAD;
   // Shadow of taps and source, so latency is checked to the exact cycle
   // A sample landing in the busy window starts nothing, so it does not restart the count
   always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         src_r   <= 1'h0;
         nt_r    <= 8'h00;
         since_r <= 9'h1FF;
      end else begin
         if (hit && idx == 8'hA4) src_r <= pwdata_in[9];
         if (hit && idx == 8'hA2) nt_r <= pwdata_in[7:0];
         if ((src_r ? alt_valid_in : own_valid_in) && since_r >= {1'h0, nt_r} + 9'h004) since_r <= 9'h001;
         else if (since_r != 9'h1FF) since_r <= since_r + 9'h001;
      end
   end
   wait_state_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
      psel_in && penable_in && !$past(penable_in) |-> !pready_out ##1 pready_out) else $error("ready not in second access cycle");
   ready_qual_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
      pready_out |-> psel_in && penable_in) else $error("ready outside access phase");
   slverr_map_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
      pready_out |-> pslverr_out == !map) else $error("error flag does not match address map");
   err_data_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
      pslverr_out |-> prdata_out == 32'h00000000) else $error("unmapped read not zero");
   coef_sign_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
      pready_out && !pwrite_in && idx <= 8'h7F |-> prdata_out[31:20] == {12{prdata_out[19]}})
      else $error("coefficient not sign extended");
   out_pulse_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
      out_valid_out |=> !out_valid_out) else $error("output strobe longer than one cycle");
   out_hold_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
      !out_valid_out |-> $stable(out_i_out) && $stable(out_q_out)) else $error("output changed without strobe");
   out_latency_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
      out_valid_out |-> since_r == {1'h0, nt_r} + 9'h004) else $error("output latency wrong");
endmodule

bind pfs_fir_stage pfs_fir_stage_asserts u_pfs_fir_stage_asserts (.sys_clk_in, .resetn_in, .psel_in, .penable_in,
   .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .own_i_in, .own_q_in, .own_valid_in,
   .alt_i_in, .alt_q_in, .alt_valid_in, .out_i_out, .out_q_out, .out_valid_out);

// >>> sim/pfs_comb_src.sv
// Upstream comb decimator model issuing one-cycle sample strobes
`timescale 1ns/1ps
module pfs_comb_src (
   input  wire logic                      sys_clk_in,
   input  wire logic                      send_in,
   input  wire logic [pfs_pkg::SMP_W-1:0] i_in,
   input  wire logic [pfs_pkg::SMP_W-1:0] q_in,
   output logic      [pfs_pkg::SMP_W-1:0] i_out,
   output logic      [pfs_pkg::SMP_W-1:0] q_out,
   output logic                           valid_out
);
   initial begin
      valid_out = 1'h0;
      i_out = 20'h00000;
      q_out = 20'h00000;
   end
   // Data toggles between strobes so a stale sample is never mistaken for a fresh one
   always @(posedge sys_clk_in) begin
      valid_out <= send_in;
      i_out     <= send_in ? i_in : ~i_out;
      q_out     <= send_in ? q_in : ~q_out;
   end
endmodule

// >>> sim/pfs_fir_stage_tb.sv
// Self-checking bench of the FIR stage
`timescale 1ns/1ps
module pfs_fir_stage_tb;
   logic        sys_clk = 1'h0;
   logic        resetn = 1'h0;
   logic        psel = 1'h0;
   logic        penable = 1'h0;
   logic        pwrite = 1'h0;
   logic [9:0]  paddr = 10'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [19:0] own_i, own_q, alt_i, alt_q;
   logic        own_v, alt_v, er;
   logic        send_own = 1'h0;
   logic        send_alt = 1'h0;
   logic [19:0] di = 20'h0;
   logic [19:0] dq = 20'h0;
   logic [23:0] out_i, out_q, cap_i, cap_q;
   logic        out_v;
   logic [31:0] rd;
   int          fail_count = 0, checked = 0, cyc = 0, outs = 0, ntp = 1, n;

   pfs_fir_stage u_pfs_fir_stage (.sys_clk_in(sys_clk), .resetn_in(resetn), .psel_in(psel), .penable_in(penable),
      .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
      .pslverr_out(pslverr), .own_i_in(own_i), .own_q_in(own_q), .own_valid_in(own_v), .alt_i_in(alt_i),
      .alt_q_in(alt_q), .alt_valid_in(alt_v), .out_i_out(out_i), .out_q_out(out_q), .out_valid_out(out_v));
   pfs_comb_src u_pfs_comb_src (.sys_clk_in(sys_clk), .send_in(send_own), .i_in(di), .q_in(dq),
      .i_out(own_i), .q_out(own_q), .valid_out(own_v));
   pfs_comb_src u_pfs_comb_src_alt (.sys_clk_in(sys_clk), .send_in(send_alt), .i_in(di), .q_in(dq),
      .i_out(alt_i), .q_out(alt_q), .valid_out(alt_v));

   always #50 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cyc++;
      if (out_v === 1'h1) begin
         outs++;
         cap_i = out_i;
         cap_q = out_q;
      end
      if (cyc == 20000) begin
         fail_count++;
         test_done();
      end
   end

   task automatic test_done;
      $display("checked %0d fail_count %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Pready is sampled before the edge updates land
   task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
      @(posedge sys_clk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= {idx, 2'h0};
      pwdata <= wd;
      @(posedge sys_clk);
      penable <= 1'h1;
      @(posedge sys_clk iff pready === 1'h1);
      rd = prdata;
      er = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
      apb(1'h0, idx, 32'h0);
      chk(rd, exp);
   endtask
   task automatic taps(input int t);
      apb(1'h1, 8'hA2, 32'(t - 1));
      ntp = t;
   endtask
   task automatic smp(input logic alt, input logic [19:0] i, input logic [19:0] q);
      @(posedge sys_clk);
      send_own <= !alt;
      send_alt <= alt;
      di <= i;
      dq <= q;
      @(posedge sys_clk);
      send_own <= 1'h0;
      send_alt <= 1'h0;
      repeat (ntp + 8) @(posedge sys_clk);
   endtask

   task automatic t_regs;
      rdchk(8'hA0, 32'h0);
      rdchk(8'hA2, 32'h0);
      rdchk(8'hA3, 32'h0);
      apb(1'h1, 8'hA1, 32'hFFFFFFFF);
      rdchk(8'hA1, 32'h000000FF);
      apb(1'h1, 8'hA1, 32'h0);
      apb(1'h1, 8'h80, 32'h1);
      chk({31'h0, er}, 32'h1);
      rdchk(8'h80, 32'h0);
      $display("regs done");
   endtask
   task automatic t_coef;
      apb(1'h1, 8'h00, 32'h2);
      apb(1'h1, 8'h01, 32'h4);
      apb(1'h1, 8'h02, 32'h123FFFF8);
      apb(1'h1, 8'h7F, 32'h2);
      apb(1'h1, 8'hA4, 32'h100);
      apb(1'h1, 8'h00, 32'h4);
      rdchk(8'h00, 32'h4);
      apb(1'h1, 8'hA4, 32'h0);
      rdchk(8'h00, 32'h2);
      rdchk(8'h02, 32'hFFFFFFF8);
      $display("coef done");
   endtask
   task automatic t_filt;
      logic [19:0] xi [3];
      logic [23:0] ei [3];
      logic [23:0] eq [3];
      xi = '{20'h80000, 20'h40000, 20'h20000};
      ei = '{24'h000008, 24'hFFFFF8, 24'hFFFFFE};
      eq = '{24'hFFFFFC, 24'hFFFFFE, 24'hFFFFFF};
      apb(1'h1, 8'hAC, 32'h1);
      repeat (160) smp(1'h0, 20'h0, 20'h0);
      taps(3);
      for (int k = 0; k < 3; k++) begin
         smp(1'h0, xi[k], 20'h40000);
         chk({8'h0, cap_i}, {8'h0, ei[k]});
         chk({8'h0, cap_q}, {8'h0, eq[k]});
      end
      $display("filter done");
   endtask
   task automatic t_dec;
      apb(1'h1, 8'hAC, 32'h0);
      apb(1'h1, 8'hA0, 32'h2);
      apb(1'h1, 8'hAC, 32'h1);
      n = outs;
      repeat (2) smp(1'h0, 20'h0, 20'h0);
      chk(outs - n, 32'h0);
      smp(1'h0, 20'h0, 20'h0);
      chk(outs - n, 32'h1);
      repeat (3) smp(1'h0, 20'h0, 20'h0);
      chk(outs - n, 32'h2);
      apb(1'h1, 8'hAC, 32'h0);
      apb(1'h1, 8'hA1, 32'h1);
      apb(1'h1, 8'hAC, 32'h1);
      n = outs;
      smp(1'h0, 20'h0, 20'h0);
      chk(outs - n, 32'h0);
      smp(1'h0, 20'h0, 20'h0);
      chk(outs - n, 32'h1);
      apb(1'h1, 8'hA0, 32'h0);
      $display("decimation done");
   endtask
   task automatic t_src;
      apb(1'h1, 8'hA4, 32'h200);
      n = outs;
      smp(1'h0, 20'h0, 20'h0);
      chk(outs - n, 32'h0);
      smp(1'h1, 20'h0, 20'h0);
      chk(outs - n, 32'h1);
      apb(1'h1, 8'hA4, 32'h0);
      $display("source done");
   endtask
   task automatic t_off;
      taps(2);
      apb(1'h1, 8'hA3, 32'h7F);
      smp(1'h0, 20'h80000, 20'h40000);
      smp(1'h0, 20'h20000, 20'h40000);
      chk({8'h0, cap_i}, 32'h00FFFFFF);
      chk({8'h0, cap_q}, 32'h00000003);
      $display("offset done");
   endtask
   // Two back-to-back samples: the second triggers while busy and must be flagged
   task automatic t_ovr;
      @(posedge sys_clk);
      send_own <= 1'h1;
      repeat (2) @(posedge sys_clk);
      send_own <= 1'h0;
      repeat (ntp + 8) @(posedge sys_clk);
      rdchk(8'hAD, 32'h00001002);
      apb(1'h1, 8'hAD, 32'h2);
      rdchk(8'hAD, 32'h00001000);
      rdchk(8'hAC, 32'h1);
      $display("overrun done");
   endtask

   initial begin
      repeat (8) @(posedge sys_clk);
      resetn <= 1'h1;
      t_regs();
      t_coef();
      t_filt();
      t_dec();
      t_src();
      t_off();
      t_ovr();
      test_done();
   end
endmodule
